// ---- design/pamw_cpu_clock_output_div.sv ----
// clock output divider with speed select and tri-state control
`timescale 1ns/10ps
`default_nettype none

module pamw_cpu_clock_output_div
  import pamw_pkg::*;
(
  input  wire logic       i_clk,      // core clock
  input  wire logic       i_rst_n,    // async reset, active low
  input  wire logic [1:0] i_speed,    // speed select
  input  wire logic       i_tristate, // float the pin when high
  output logic            o_clk,      // divided clock level
  output logic            o_oe        // pin driver enable
);

  // ************************************************************
  // state
  // ************************************************************
  logic [1:0] cnt_reg;   // half-period counter
  logic [1:0] cnt_next;
  logic       clk_reg;   // output clock level
  logic       clk_next;
  logic       oe_reg;    // output enable
  logic       oe_next;
  logic [1:0] half;      // chosen half-period terminal count

  // next state: all speeds derive from the same core clock, so every
  // choice stays phase locked to the crystal reference
  always_comb begin
    case (i_speed)
      SPEED_12: half = HALF_12;    // default after reset
      SPEED_24: half = HALF_24;
      SPEED_48: half = HALF_48;
      default:  half = HALF_48;    // spare code runs fastest
    endcase
    if (cnt_reg >= half) begin
      cnt_next = 2'h0;
      clk_next = ~clk_reg;         // one phase-locked edge
    end else begin
      cnt_next = cnt_reg + 2'h1;
      clk_next = clk_reg;
    end
    oe_next = ~i_tristate;         // float when software asks
  end

  // registers only
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg <= 2'h0;
      clk_reg <= 1'b0;
      oe_reg  <= 1'b1;
    end else begin
      cnt_reg <= cnt_next;
      clk_reg <= clk_next;
      oe_reg  <= oe_next;
    end
  end

  assign o_clk = clk_reg;
  assign o_oe  = oe_reg;

  // slowest speed holds each level for four cycles
  clk_slow_hold_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_speed == SPEED_12) [*5] ##0 $changed(clk_reg) |->
      $past(clk_reg, 1) == $past(clk_reg, 4))
    else $error("clock output level not held four cycles");

endmodule

`default_nettype wire

// ---- design/pamw_pkg.sv ----
// package: register map, field positions, reset values and counts
package pamw_pkg;

  // ************************************************************
  // bus widths
  // ************************************************************
  localparam int ADDR_W = 4;                  // register address width
  localparam int DATA_W = 8;                  // register data width

  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [3:0] OFF_CPU_CTRL  = 4'h0; // cpu_control_status
  localparam logic [3:0] OFF_ALT_CFG   = 4'h1; // port_a_alt_config
  localparam logic [3:0] OFF_IF_CFG    = 4'h2; // interface_config
  localparam logic [3:0] OFF_FIFO_POL  = 4'h3; // fifo_pin_polarity
  localparam logic [3:0] OFF_PA_OE     = 4'h4; // port_a_output_enable
  localparam logic [3:0] OFF_PA_DATA   = 4'h5; // port data, reads pins
  localparam logic [3:0] OFF_WAKE_CTRL = 4'h6; // resume control
  localparam logic [3:0] OFF_TRIG      = 4'h7; // trigger type and pending

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int BIT_CLK_TRI    = 1;  // cpu_control_status: float clock pin
  localparam int BIT_SPEED_LO   = 3;  // cpu_control_status: speed [4:3]
  localparam int BIT_SPEED_HI   = 4;
  localparam int BIT_ALT_IRQ0   = 0;  // port_a_alt_config: pin 0 is irq
  localparam int BIT_ALT_IRQ1   = 1;  // port_a_alt_config: pin 1 is irq
  localparam int BIT_RD_POL     = 4;  // fifo_pin_polarity: read drive level
  localparam int BIT_WAKE_EN    = 1;  // resume control: enable
  localparam int BIT_WAKE_POL   = 4;  // resume control: polarity
  localparam int BIT_WAKE_FLAG  = 6;  // resume control: event flag, w1c
  localparam int BIT_WAKE_SEL   = 7;  // resume control: pin 3 function
  localparam int BIT_TRIG0      = 0;  // irq_zero_trigger_type
  localparam int BIT_TRIG1      = 1;  // irq_one_trigger_type
  localparam int BIT_PEND0      = 4;  // irq zero edge pending, w1c
  localparam int BIT_PEND1      = 5;  // irq one edge pending, w1c

  // ************************************************************
  // interface modes and clock speeds
  // ************************************************************
  localparam logic [1:0] IF_MODE_PORT   = 2'h0; // plain port pins
  localparam logic [1:0] IF_MODE_MASTER = 2'h2; // programmable master
  localparam logic [1:0] IF_MODE_SLAVE  = 2'h3; // slave fifo
  localparam logic [1:0] SPEED_12       = 2'h0; // slowest clock
  localparam logic [1:0] SPEED_24       = 2'h1; // middle clock
  localparam logic [1:0] SPEED_48       = 2'h2; // fastest clock

  // ************************************************************
  // divider counts: half periods of the clock output in cycles, minus one
  // ************************************************************
  localparam logic [1:0] HALF_12 = 2'h3;       // toggle every 4 cycles
  localparam logic [1:0] HALF_24 = 2'h1;       // toggle every 2 cycles
  localparam logic [1:0] HALF_48 = 2'h0;       // toggle every cycle

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] RST_REG8 = 8'h00;     // all control bytes clear
  localparam logic [3:0] RST_NIB  = 4'h0;      // port nibbles clear

endpackage

// ---- design/pamw_port_a_mux.sv ----
// port a pin mux: four pins, external irqs, fifo read drive, resume pin
//
// Functional notes
// - clock output phase locked, three speeds
// - clock output starts at slowest speed
// - control bit one floats the clock pin
// - pin zero: port bit or irq zero
// - irq zero edge or level by type
// - pin one: port bit or irq one
// - pin two: port bit or read drive
// - read drive gates fifo bus, programmable polarity
// - pin three function from resume select, enable
// - resume pin needs enable, polarity programmable
// - resume transition in suspend restarts, interrupts
// - asserted resume pin blocks suspend entry
// - low reset pin clears all logic but sets the clock output enable
// - mode bits choose port or slave fifo; master code gives port behaviour
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module pamw_port_a_mux
  import pamw_pkg::*;
(
  input  wire logic        i_clk,          // core clock, 10 MHz
  input  wire logic        i_rst_n,        // reset pin, active low
  input  wire logic [3:0]  i_addr,         // register address
  input  wire logic [7:0]  i_wdata,        // register write data
  input  wire logic        i_wr,           // write strobe
  input  wire logic        i_rd,           // read strobe
  output logic      [7:0]  o_rdata,        // read data, cycle after i_rd
  input  wire logic [3:0]  i_pa_in,        // port a pin levels
  output logic      [3:0]  o_pa_out,       // port a drive levels
  output logic      [3:0]  o_pa_oe,        // port a drive enables
  input  wire logic        i_cpu_suspended,// processor is suspended
  output logic             o_irq_zero,     // irq zero request to cpu
  output logic             o_irq_one,      // irq one request to cpu
  output logic             o_fifo_bus_oe,  // fifo data bus drive enable
  output logic             o_wake_osc,     // one-cycle oscillator start
  output logic             o_wake_irq,     // resume interrupt, sticky
  output logic             o_suspend_block,// forbid suspend entry
  output logic             o_cpu_clock_output,       // clock output level
  output logic             o_cpu_clock_output_oe     // clock output enable
);

  // ************************************************************
  // control registers
  // ************************************************************
  logic [7:0] cpu_ctrl_reg, cpu_ctrl_next;   // cpu_control_status
  logic [7:0] alt_cfg_reg,  alt_cfg_next;    // port_a_alt_config
  logic [7:0] if_cfg_reg,   if_cfg_next;     // interface_config
  logic [7:0] fifo_pol_reg, fifo_pol_next;   // fifo_pin_polarity
  logic [3:0] pa_oe_reg,    pa_oe_next;      // port_a_output_enable
  logic [3:0] pa_dat_reg,   pa_dat_next;     // port output data
  logic [7:0] wake_reg,     wake_next;       // resume control
  logic [7:0] trig_reg,     trig_next;       // trigger types, pending
  logic [7:0] rdata_reg,    rdata_next;      // read return

  // ************************************************************
  // pin state
  // ************************************************************
  logic [3:0] pin_prev_reg, pin_prev_next;   // last cycle pin levels
  logic [3:0] oe_out_reg,   oe_out_next;     // registered pin enables
  logic       irq0_reg,     irq0_next;       // irq zero request
  logic       irq1_reg,     irq1_next;       // irq one request
  logic       fifo_oe_reg,  fifo_oe_next;    // fifo bus enable
  logic       osc_reg,      osc_next;        // oscillator start pulse
  logic       blk_reg,      blk_next;        // suspend block

  // decoded functions
  logic       alt0, alt1, alt2, alt3;        // pin in alternate role
  logic       fell0, fell1;                  // falling edges on irq pins
  logic       wake_on;                       // resume input active
  logic       wake_edge;                     // resume pin transition
  logic       wake_assert;                   // resume pin at its level

  // ************************************************************
  // function decode
  // ************************************************************
  // combinational decode of pin roles from the config registers
  always_comb begin
    alt0 = alt_cfg_reg[BIT_ALT_IRQ0];
    alt1 = alt_cfg_reg[BIT_ALT_IRQ1];
    // spare mode code falls back to port behaviour
    alt2 = (if_cfg_reg[1:0] == IF_MODE_SLAVE);
    alt3 = wake_reg[BIT_WAKE_SEL] & ~pa_oe_reg[3];
    wake_on = alt3 & wake_reg[BIT_WAKE_EN];
    wake_assert = wake_on & (i_pa_in[3] == wake_reg[BIT_WAKE_POL]);
    // history resets low, but wake_on is off after reset, so a pin that
    // idles high cannot fake a resume transition
    wake_edge = wake_on & (i_pa_in[3] ^ pin_prev_reg[3]);
    // a low history after reset gives no false falling edge
    fell0 = pin_prev_reg[0] & ~i_pa_in[0];
    fell1 = pin_prev_reg[1] & ~i_pa_in[1];
  end

  // ************************************************************
  // register file
  // ************************************************************
  // next values of the control bytes; flags set by hardware win over a
  // software clear in the same cycle so no event is lost
  always_comb begin
    cpu_ctrl_next = cpu_ctrl_reg;
    alt_cfg_next  = alt_cfg_reg;
    if_cfg_next   = if_cfg_reg;
    fifo_pol_next = fifo_pol_reg;
    pa_oe_next    = pa_oe_reg;
    pa_dat_next   = pa_dat_reg;
    wake_next     = wake_reg;
    trig_next     = trig_reg;
    if (i_wr) begin
      case (i_addr)
        OFF_CPU_CTRL:  cpu_ctrl_next = i_wdata;
        OFF_ALT_CFG:   alt_cfg_next  = i_wdata;
        OFF_IF_CFG:    if_cfg_next   = i_wdata;
        OFF_FIFO_POL:  fifo_pol_next = i_wdata;
        OFF_PA_OE:     pa_oe_next    = i_wdata[3:0];
        OFF_PA_DATA:   pa_dat_next   = i_wdata[3:0];
        OFF_WAKE_CTRL: begin
          // flag is write-one-to-clear, other bits plain storage
          wake_next = {i_wdata[7], wake_reg[6] & ~i_wdata[6],
                       i_wdata[5:0]};
        end
        OFF_TRIG: begin
          trig_next = {2'h0, trig_reg[5] & ~i_wdata[5],
                       trig_reg[4] & ~i_wdata[4], i_wdata[3:0]};
        end
        default: begin
          // unmapped address: write ignored
        end
      endcase
    end
    // edge events latch into pending bits
    if (alt0 & trig_reg[BIT_TRIG0] & fell0) begin
      trig_next[BIT_PEND0] = 1'b1;
    end
    if (alt1 & trig_reg[BIT_TRIG1] & fell1) begin
      trig_next[BIT_PEND1] = 1'b1;
    end
    // any transition of the enabled resume pin while suspended raises the resume interrupt
    if (wake_edge & i_cpu_suspended) begin
      wake_next[BIT_WAKE_FLAG] = 1'b1;
    end
  end

  // read mux: data appear the cycle after the strobe and only then
  always_comb begin
    rdata_next = 8'h00;
    if (i_rd) begin
      case (i_addr)
        OFF_CPU_CTRL:  rdata_next = cpu_ctrl_reg;
        OFF_ALT_CFG:   rdata_next = alt_cfg_reg;
        OFF_IF_CFG:    rdata_next = if_cfg_reg;
        OFF_FIFO_POL:  rdata_next = fifo_pol_reg;
        OFF_PA_OE:     rdata_next = {4'h0, pa_oe_reg};
        OFF_PA_DATA:   rdata_next = {4'h0, i_pa_in};  // live pin levels
        OFF_WAKE_CTRL: rdata_next = wake_reg;
        OFF_TRIG:      rdata_next = trig_reg;
        default:       rdata_next = 8'h00;            // unmapped reads 0
      endcase
    end
  end

  // ************************************************************
  // pin drive and request outputs
  // ************************************************************
  // enables drop one cycle after a pin takes its alternate input role, so a
  // stale output enable can fight the outside driver for that one cycle only
  always_comb begin
    pin_prev_next = i_pa_in;
    oe_out_next   = pa_oe_reg & ~{alt3, alt2, alt1, alt0};
    // level mode: request follows the low pin; edge mode: pending bit
    irq0_next = alt0 & (trig_reg[BIT_TRIG0] ? trig_next[BIT_PEND0]
                                            : ~i_pa_in[0]);
    irq1_next = alt1 & (trig_reg[BIT_TRIG1] ? trig_next[BIT_PEND1]
                                            : ~i_pa_in[1]);
    // external party drives read enable; bus drives at chosen level
    fifo_oe_next = alt2 &
                   (i_pa_in[2] == fifo_pol_reg[BIT_RD_POL]);
    osc_next = wake_edge & i_cpu_suspended;
    blk_next = wake_assert;
  end

  // all state clears while the reset pin is low, except the divider's clock output enable, which sets
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cpu_ctrl_reg <= RST_REG8;
      alt_cfg_reg  <= RST_REG8;
      if_cfg_reg   <= RST_REG8;
      fifo_pol_reg <= RST_REG8;
      pa_oe_reg    <= RST_NIB;
      pa_dat_reg   <= RST_NIB;
      wake_reg     <= RST_REG8;
      trig_reg     <= RST_REG8;
      rdata_reg    <= RST_REG8;
      pin_prev_reg <= RST_NIB;
      oe_out_reg   <= RST_NIB;
      irq0_reg     <= 1'b0;
      irq1_reg     <= 1'b0;
      fifo_oe_reg  <= 1'b0;
      osc_reg      <= 1'b0;
      blk_reg      <= 1'b0;
    end else begin
      cpu_ctrl_reg <= cpu_ctrl_next;
      alt_cfg_reg  <= alt_cfg_next;
      if_cfg_reg   <= if_cfg_next;
      fifo_pol_reg <= fifo_pol_next;
      pa_oe_reg    <= pa_oe_next;
      pa_dat_reg   <= pa_dat_next;
      wake_reg     <= wake_next;
      trig_reg     <= trig_next;
      rdata_reg    <= rdata_next;
      pin_prev_reg <= pin_prev_next;
      oe_out_reg   <= oe_out_next;
      irq0_reg     <= irq0_next;
      irq1_reg     <= irq1_next;
      fifo_oe_reg  <= fifo_oe_next;
      osc_reg      <= osc_next;
      blk_reg      <= blk_next;
    end
  end

  // ************************************************************
  // clock output
  // ************************************************************
  pamw_cpu_clock_output_div u_cpu_clock_output (
    .i_clk      (i_clk),
    .i_rst_n    (i_rst_n),
    .i_speed    (cpu_ctrl_reg[BIT_SPEED_HI:BIT_SPEED_LO]),
    .i_tristate (cpu_ctrl_reg[BIT_CLK_TRI]),
    .o_clk      (o_cpu_clock_output),
    .o_oe       (o_cpu_clock_output_oe)
  );

  assign o_rdata         = rdata_reg;
  assign o_pa_out        = pa_dat_reg;
  assign o_pa_oe         = oe_out_reg;
  assign o_irq_zero      = irq0_reg;
  assign o_irq_one       = irq1_reg;
  assign o_fifo_bus_oe   = fifo_oe_reg;
  assign o_wake_osc      = osc_reg;
  assign o_wake_irq      = wake_reg[BIT_WAKE_FLAG];
  assign o_suspend_block = blk_reg;

  // ************************************************************
  // checks
  // ************************************************************
  clk_tristate_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    cpu_ctrl_reg[BIT_CLK_TRI] |=> !o_cpu_clock_output_oe)
    else $error("clock pin driven while tri-state requested");

  clk_drive_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    !cpu_ctrl_reg[BIT_CLK_TRI] |=> o_cpu_clock_output_oe)
    else $error("clock pin floating while drive requested");

  irq0_level_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    alt_cfg_reg[0] && !trig_reg[0] && !i_pa_in[0] |=> o_irq_zero)
    else $error("level irq zero not raised for low pin");

  irq0_edge_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    alt_cfg_reg[0] && trig_reg[0] && $fell(i_pa_in[0])
      |=> o_irq_zero && trig_reg[4])
    else $error("edge irq zero not latched");

  irq1_edge_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    alt_cfg_reg[1] && trig_reg[1] && $fell(i_pa_in[1])
      |=> o_irq_one && trig_reg[5])
    else $error("edge irq one not latched");

  // the pin enable follows the register one cycle late, so compare with
  // the value the register held when the enable was computed
  irq1_mode_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    !alt_cfg_reg[1] |=> !o_irq_one && o_pa_oe[1] == $past(pa_oe_reg[1]))
    else $error("irq one active while pin one is a port bit");

  alt_oe_off_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    alt0 || alt1 || alt2 || alt3
      |=> (o_pa_oe & $past({alt3, alt2, alt1, alt0})) == 4'h0)
    else $error("pin driven while serving an alternate input");

  fifo_drive_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    o_fifo_bus_oe |-> $past(if_cfg_reg[1:0]) == IF_MODE_SLAVE &&
      $past(i_pa_in[2]) == $past(fifo_pol_reg[4]))
    else $error("fifo bus enabled without matching read drive");

  wake_event_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    wake_on && i_cpu_suspended && $changed(i_pa_in[3])
      |=> o_wake_osc && o_wake_irq)
    else $error("resume transition did not wake");

  // the start pulse repeats only if the pin moved again; a pin that
  // toggles every cycle legally keeps it high
  wake_pulse_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    o_wake_osc |-> $past(wake_on && i_cpu_suspended) &&
      $past(i_pa_in[3]) != $past(i_pa_in[3], 2))
    else $error("oscillator start without resume transition");

  wake_block_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    o_suspend_block |-> $past(wake_reg[1]) && !$past(pa_oe_reg[3]))
    else $error("suspend blocked without enabled resume pin");

  port_dir_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    $rose(i_rst_n) |-> o_pa_oe == 4'h0 && !o_irq_zero)
    else $error("port pins not inputs after reset");

endmodule

`default_nettype wire

// ---- dv/pamw_board_model.sv ----
// board model: external drivers on the four port a pins
`timescale 1ns/10ps
`default_nettype none

module pamw_board_model (
  input  wire logic       i_clk,     // core clock
  input  wire logic [3:0] i_drv,     // board drive levels
  input  wire logic [3:0] i_drv_en,  // board drive enables
  input  wire logic [3:0] i_dev_out, // device drive levels
  input  wire logic [3:0] i_dev_oe,  // device drive enables
  output logic      [3:0] o_pin      // resolved pin levels
);
  // ************************************************************
  // pin resolution
  // ************************************************************
  logic [3:0] last_reg = 4'h0; // last driven level, no pull on these pins

  // device wins a clash; an undriven pin shows the inverse of its last
  // driven level so a floating pin never passes for a held value
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (i_dev_oe[i]) o_pin[i] = i_dev_out[i];
      else if (i_drv_en[i]) o_pin[i] = i_drv[i];
      else o_pin[i] = ~last_reg[i];
    end
  end

  // remember the last driven level; a floating pin must not oscillate
  always @(posedge i_clk) begin
    for (int i = 0; i < 4; i++) begin
      if (i_dev_oe[i] || i_drv_en[i]) last_reg[i] <= o_pin[i];
    end
  end
endmodule
`default_nettype wire

// ---- dv/test_pamw_port_a_mux.sv ----
// testbench for the port a pin mux
`timescale 1ns/10ps
`default_nettype none

module test_pamw_port_a_mux;
  import pamw_pkg::*;
  // ************************************************************
  // signals
  // ************************************************************
  logic       i_clk = 0, i_rst_n = 0, i_wr = 0, i_rd = 0, susp = 0;
  logic [3:0] i_addr = 0, drv = 0, drv_en = 0, pin, pa_out, pa_oe;
  logic [7:0] i_wdata = 0, o_rdata;
  logic       irq0, irq1, fifo_oe, osc, wirq, blk, clko, clko_oe;
  int         fails = 0, cmp_count = 0, osc_cnt = 0;

  always #50 i_clk = ~i_clk; // 10 MHz

  pamw_port_a_mux dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_pa_in(pin), .o_pa_out(pa_out), .o_pa_oe(pa_oe),
    .i_cpu_suspended(susp), .o_irq_zero(irq0), .o_irq_one(irq1),
    .o_fifo_bus_oe(fifo_oe), .o_wake_osc(osc), .o_wake_irq(wirq),
    .o_suspend_block(blk), .o_cpu_clock_output(clko), .o_cpu_clock_output_oe(clko_oe));

  pamw_board_model board (.i_clk(i_clk), .i_drv(drv), .i_drv_en(drv_en),
    .i_dev_out(pa_out), .i_dev_oe(pa_oe), .o_pin(pin));

  // one-cycle pulses are counted in the cycle they stand
  always @(posedge i_clk) if (osc === 1'b1) osc_cnt++;

  // ************************************************************
  // tasks
  // ************************************************************
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1; i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata; // stands only in this cycle
  endtask

  task automatic rdchk(input string nm, input logic [3:0] a,
                       input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    check(nm, d, exp);
  endtask

  // board drives pins, then one sample edge and one output edge pass
  task automatic pins(input logic [3:0] en, input logic [3:0] v);
    @(posedge i_clk);
    drv_en <= en; drv <= v;
    repeat (2) @(posedge i_clk);
    #1;
  endtask

  // cycles between two changes of the clock output pin
  task automatic half(input logic [7:0] exp);
    logic l;
    int   n;
    for (int k = 0; k < 2; k++) begin
      @(posedge i_clk); #1 l = clko; n = 0;
      while (clko === l && n < 20) begin @(posedge i_clk); #1 n++; end
    end
    l = clko; n = 0;
    while (clko === l && n < 20) begin @(posedge i_clk); #1 n++; end
    if (n >= 20) begin fails++; summarize(); end
    check("clk half", n[7:0], exp);
  endtask

  task automatic done(input string nm);
    $display("test %s done", nm);
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  logic [7:0] spd [4] = '{8'h00, 8'h08, 8'h10, 8'h18};
  logic [7:0] hlf [4] = '{8'h04, 8'h02, 8'h01, 8'h01};
  int         c0;

  initial begin
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    // reset values, unmapped address
    for (int a = 0; a < 8; a++)
      if (a != 5) rdchk("reg reset", a[3:0], RST_REG8);
    rdchk("unmapped", 4'h9, 8'h00);
    check("pa oe reset", {4'h0, pa_oe}, 8'h00);
    check("fifo oe reset", {7'h0, fifo_oe}, 8'h00);
    check("clk oe reset", {7'h0, clko_oe}, 8'h01);
    half(8'h04);
    done("reset");
    // clock speeds and tri-state
    for (int s = 0; s < 4; s++) begin
      wr(OFF_CPU_CTRL, spd[s]);
      half(hlf[s]);
    end
    wr(OFF_CPU_CTRL, 8'h02);
    @(posedge i_clk); #1;
    check("clk oe float", {7'h0, clko_oe}, 8'h00);
    done("clock");
    // port bits and alternate irq roles
    wr(OFF_PA_OE, 8'h0F); wr(OFF_PA_DATA, 8'h0A);
    @(posedge i_clk); #1;
    check("pa out", {4'h0, pa_out}, 8'h0A);
    rdchk("pa pins", OFF_PA_DATA, 8'h0A);
    wr(OFF_ALT_CFG, 8'h03);
    @(posedge i_clk); #1;
    check("pa oe alt", {4'h0, pa_oe}, 8'h0C);
    wr(OFF_PA_OE, 8'h00);
    pins(4'hF, 4'hF);
    wr(OFF_TRIG, 8'h00);
    pins(4'hF, 4'hC);
    check("irq level", {6'h0, irq1, irq0}, 8'h03);
    pins(4'hF, 4'hF);
    check("irq level off", {6'h0, irq1, irq0}, 8'h00);
    wr(OFF_TRIG, 8'h03);
    pins(4'hF, 4'hC); pins(4'hF, 4'hF);
    check("irq edge held", {6'h0, irq1, irq0}, 8'h03);
    rdchk("pending", OFF_TRIG, 8'h33);
    wr(OFF_TRIG, 8'h13);
    @(posedge i_clk); #1;
    check("irq clear", {6'h0, irq1, irq0}, 8'h02);
    wr(OFF_ALT_CFG, 8'h00);
    pins(4'hF, 4'hC);
    check("irq port role", {7'h0, irq0}, 8'h00);
    done("irq");
    // fifo read drive across modes and polarities
    wr(OFF_IF_CFG, {6'h0, IF_MODE_SLAVE}); wr(OFF_FIFO_POL, 8'h10);
    pins(4'hF, 4'h4);
    check("fifo oe high", {7'h0, fifo_oe}, 8'h01);
    wr(OFF_FIFO_POL, 8'h00);
    @(posedge i_clk); #1;
    check("fifo oe pol", {7'h0, fifo_oe}, 8'h00);
    pins(4'hF, 4'h0);
    check("fifo oe low", {7'h0, fifo_oe}, 8'h01);
    wr(OFF_PA_OE, 8'h04);
    @(posedge i_clk); #1;
    check("pin2 oe alt", {7'h0, pa_oe[2]}, 8'h00);
    wr(OFF_IF_CFG, {6'h0, IF_MODE_MASTER});
    @(posedge i_clk); #1;
    check("fifo oe master", {7'h0, fifo_oe}, 8'h00);
    wr(OFF_IF_CFG, {6'h0, IF_MODE_PORT});
    @(posedge i_clk); #1;
    check("pin2 oe port", {7'h0, pa_oe[2]}, 8'h01);
    done("fifo");
    // resume pin in suspend
    wr(OFF_PA_OE, 8'h00); pins(4'h8, 4'h8);
    @(posedge i_clk) susp <= 1'b1;
    wr(OFF_WAKE_CTRL, 8'h82);
    c0 = osc_cnt;
    pins(4'h8, 4'h0);
    check("wake pulses", 8'(osc_cnt - c0), 8'h01);
    check("wake irq", {7'h0, wirq}, 8'h01);
    check("block", {7'h0, blk}, 8'h01);
    pins(4'h8, 4'h8);
    check("block off", {7'h0, blk}, 8'h00);
    wr(OFF_WAKE_CTRL, 8'hD2); pins(4'h8, 4'h8);
    check("block pol", {7'h0, blk}, 8'h01);
    wr(OFF_WAKE_CTRL, 8'h80);
    c0 = osc_cnt;
    pins(4'h8, 4'h0);
    check("block disabled", {7'h0, blk}, 8'h00);
    pins(4'h8, 4'h8);
    check("wake disabled", 8'(osc_cnt - c0), 8'h00);
    check("wake flag w1c", {7'h0, wirq}, 8'h00);
    wr(OFF_WAKE_CTRL, 8'h82); wr(OFF_PA_OE, 8'h08);
    c0 = osc_cnt;
    wr(OFF_PA_DATA, 8'h00); wr(OFF_PA_DATA, 8'h08);
    repeat (2) @(posedge i_clk);
    check("pin3 port role", 8'(osc_cnt - c0), 8'h00);
    done("wake");
    // reset in mid-run
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rdchk("oe after reset", OFF_PA_OE, RST_REG8);
    rdchk("wake after reset", OFF_WAKE_CTRL, RST_REG8);
    check("pa oe after reset", {4'h0, pa_oe}, 8'h00);
    done("reset again");
    summarize();
  end
endmodule
`default_nettype wire
